// File: mcg_gateway.sv
// Purpose : Coil handling of the serial slave card, meter side sequencing
// Assumes : Front end delivers decoded coil, value and register commands
// Notes   : One meter transaction at a time; master work preempts polling
`default_nettype none

module mcg_gateway #(
    parameter int VAL_W = 32
) (
    input  wire logic                     SYS_CLK,
    input  wire logic                     RST,
    input  wire logic                     CMD_VALID,
    input  wire logic [2:0]               CMD_KIND,
    input  wire logic [15:0]              CMD_ADDR,
    input  wire logic [VAL_W-1:0]         CMD_WDATA,
    output      logic                     CMD_READY,
    output      logic                     RSP_VALID,
    output      logic                     RSP_ERR,
    output      logic [VAL_W-1:0]         RSP_DATA,
    input  wire logic [3:0]               SP_OUT_STATE,
    input  wire logic [3:0]               SP_MANUAL,
    output      logic                     MTR_REQ,
    output      logic [1:0]               MTR_OP,
    output      logic [4:0]               MTR_SEL,
    output      logic [VAL_W-1:0]         MTR_WDATA,
    output      logic [7:0]               MTR_TERM,
    input  wire logic                     MTR_ACK,
    input  wire logic [VAL_W-1:0]         MTR_RDATA,
    input  wire logic                     NV_LOAD_VALID,
    input  wire logic [19:0]              NV_LOAD_DATA,
    output      logic                     NV_SAVE,
    output      logic [19:0]              NV_SAVE_DATA
);

    localparam int NV = mcg_pkg::NUM_VAL;
    localparam int IW = mcg_pkg::IDX_W;

    typedef enum {MCG_ST_LOAD, MCG_ST_IDLE, MCG_ST_BUSY} mcg_state_t;

    typedef struct packed {
        mcg_state_t        st;
        logic [NV-1:0]     poll;
        logic              delay;
        logic [NV-1:0]     term;
        logic [NV-1:0]     init_left;
        logic [mcg_pkg::NUM_RST-1:0] rst_pend;
        logic [mcg_pkg::NUM_OUT-1:0] out_pend;
        logic [mcg_pkg::NUM_OUT-1:0] out_val;
        logic              slot_busy;
        logic              slot_write;
        logic              slot_rsp;
        logic [IW-1:0]     slot_idx;
        logic [VAL_W-1:0]  slot_data;
        mcg_pkg::mcg_src_t cur_src;
        logic [IW-1:0]     cur_idx;
        logic [IW-1:0]     poll_idx;
        logic              mtr_req;
        mcg_pkg::mcg_mop_t mtr_op;
        logic [4:0]        mtr_sel;
        logic [VAL_W-1:0]  mtr_wdata;
        logic [7:0]        mtr_term;
        logic              cmd_ready;
        logic              rsp_valid;
        logic              rsp_err;
        logic [VAL_W-1:0]  rsp_data;
        logic              nv_save;
        logic [19:0]       nv_data;
    } mcg_gw_state_t;

    mcg_gw_state_t s_q;
    mcg_gw_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [2:0] first_set(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = i[2:0];
            end
        end
        return r;
    endfunction

    // Terminating character for a meter write of one value
    function automatic logic [7:0] term_char(input logic flag);
        return flag ? mcg_pkg::CHAR_SAVE : mcg_pkg::CHAR_NOSAVE;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sub-blocks

    logic              vs_wr_en;
    logic [VAL_W-1:0]  vs_rd_data;
    logic [IW-1:0]     ps_nxt;
    logic              ps_any;

    mcg_value_store #(
        .VAL_W   (VAL_W)
    ) u_store (
        .clk     (SYS_CLK),
        .rst     (RST),
        .wr_en   (vs_wr_en),
        .wr_idx  (s_q.cur_idx),
        .wr_data (MTR_RDATA),
        .rd_idx  (CMD_ADDR[IW-1:0]),
        .rd_data (vs_rd_data)
    );

    // Power-up sweep joins the enabled set until each value is fetched
    mcg_poll_sel u_sel (
        .mask (s_q.poll | s_q.init_left),
        .cur  (s_q.poll_idx),
        .nxt  (ps_nxt),
        .any  (ps_any)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [2:0]  k;
        logic [15:0] off;
        logic        cmd_take;
        logic        idx_ok;
        mcg_pkg::mcg_cmd_t kind;
        k        = 3'h0;
        off      = 16'h0000;
        kind     = mcg_pkg::mcg_cmd_t'(CMD_KIND);
        cmd_take = CMD_VALID && s_q.cmd_ready;
        idx_ok   = int'(CMD_ADDR) < NV;
        s_d      = s_q;
        vs_wr_en = 1'b0;
        s_d.rsp_valid = 1'b0;
        s_d.nv_save   = 1'b0;

        case (s_q.st)
            MCG_ST_LOAD: begin
                if (NV_LOAD_VALID) begin
                    s_d.poll  = NV_LOAD_DATA[NV-1:0];
                    s_d.delay = NV_LOAD_DATA[mcg_pkg::NV_DELAY_BIT];
                end
                s_d.st = MCG_ST_IDLE;
            end
            MCG_ST_IDLE: begin
                // Only one command on the meter link at a time
                s_d.mtr_req = 1'b1;
                s_d.st      = MCG_ST_BUSY;
                if (|s_q.rst_pend) begin
                    k = first_set({2'b00, s_q.rst_pend});
                    s_d.cur_src = mcg_pkg::MCG_SRC_RESET;
                    s_d.mtr_op  = mcg_pkg::MCG_MTR_RESET;
                    s_d.mtr_sel = {2'b00, k};
                    s_d.cur_idx = {2'b00, k};
                end else if (|s_q.out_pend) begin
                    k = first_set({4'h0, s_q.out_pend});
                    s_d.cur_src   = mcg_pkg::MCG_SRC_OUT;
                    s_d.mtr_op    = mcg_pkg::MCG_MTR_OUTPUT;
                    s_d.mtr_sel   = {2'b00, k};
                    s_d.cur_idx   = {2'b00, k};
                    s_d.mtr_wdata = '0;
                    s_d.mtr_wdata[0] = s_q.out_val[k[1:0]];
                end else if (s_q.slot_busy && s_q.slot_write) begin
                    s_d.cur_src   = mcg_pkg::MCG_SRC_MWRITE;
                    s_d.mtr_op    = mcg_pkg::MCG_MTR_WRITE;
                    s_d.mtr_sel   = s_q.slot_idx;
                    s_d.cur_idx   = s_q.slot_idx;
                    s_d.mtr_wdata = s_q.slot_data;
                    s_d.mtr_term  = term_char(s_q.term[s_q.slot_idx]);
                end else if (s_q.slot_busy) begin
                    s_d.cur_src = mcg_pkg::MCG_SRC_MREAD;
                    s_d.mtr_op  = mcg_pkg::MCG_MTR_READ;
                    s_d.mtr_sel = s_q.slot_idx;
                    s_d.cur_idx = s_q.slot_idx;
                end else if (ps_any) begin
                    // Fewer enabled values shorten the loop
                    s_d.cur_src  = mcg_pkg::MCG_SRC_POLL;
                    s_d.mtr_op   = mcg_pkg::MCG_MTR_READ;
                    s_d.mtr_sel  = ps_nxt;
                    s_d.cur_idx  = ps_nxt;
                    s_d.poll_idx = ps_nxt;
                end else begin
                    s_d.mtr_req = 1'b0;
                    s_d.st      = MCG_ST_IDLE;
                end
            end
            MCG_ST_BUSY: begin
                if (MTR_ACK) begin
                    s_d.mtr_req = 1'b0;
                    s_d.st      = MCG_ST_IDLE;
                    case (s_q.cur_src)
                        mcg_pkg::MCG_SRC_RESET: begin
                            s_d.rst_pend[s_q.cur_idx[2:0]] = 1'b0;
                        end
                        mcg_pkg::MCG_SRC_OUT: begin
                            s_d.out_pend[s_q.cur_idx[1:0]] = 1'b0;
                        end
                        mcg_pkg::MCG_SRC_MWRITE: begin
                            // Read the written value back next
                            s_d.slot_write = 1'b0;
                        end
                        default: begin
                            vs_wr_en = 1'b1;
                            s_d.init_left[s_q.cur_idx] = 1'b0;
                            if (s_q.cur_src == mcg_pkg::MCG_SRC_MREAD) begin
                                s_d.slot_busy = 1'b0;
                                if (s_q.slot_rsp) begin
                                    s_d.rsp_valid = 1'b1;
                                    s_d.rsp_err   = 1'b0;
                                    s_d.rsp_data  = MTR_RDATA;
                                end
                            end
                        end
                    endcase
                end
            end
            default: begin
                s_d.st = MCG_ST_IDLE;
            end
        endcase

        ////////////////////////////////////////////////////////////////////
        // Master commands; placed after the meter side so sets win clears

        if (cmd_take) begin
            s_d.rsp_valid = 1'b1;
            s_d.rsp_err   = 1'b0;
            s_d.rsp_data  = '0;
            if (kind == mcg_pkg::MCG_COIL_RD) begin
                if (CMD_ADDR < mcg_pkg::COIL_RST_BASE) begin
                    s_d.rsp_data[0] = SP_OUT_STATE[CMD_ADDR[1:0]];
                end else if (CMD_ADDR < mcg_pkg::COIL_POLL_BASE) begin
                    s_d.rsp_data[0] = 1'b0;
                end else if (CMD_ADDR < mcg_pkg::COIL_DELAY) begin
                    off = CMD_ADDR - mcg_pkg::COIL_POLL_BASE;
                    s_d.rsp_data[0] = s_q.poll[off[IW-1:0]];
                end else if (CMD_ADDR == mcg_pkg::COIL_DELAY) begin
                    s_d.rsp_data[0] = s_q.delay;
                end else if (CMD_ADDR <= mcg_pkg::COIL_LAST) begin
                    off = CMD_ADDR - mcg_pkg::COIL_TERM_BASE;
                    s_d.rsp_data[0] = s_q.term[off[IW-1:0]];
                end else begin
                    s_d.rsp_err = 1'b1;
                end
            end else if (kind == mcg_pkg::MCG_COIL_WR) begin
                if (CMD_ADDR < mcg_pkg::COIL_RST_BASE) begin
                    // Outputs in automatic mode ignore the write
                    if (SP_MANUAL[CMD_ADDR[1:0]]) begin
                        s_d.out_pend[CMD_ADDR[1:0]] = 1'b1;
                        s_d.out_val[CMD_ADDR[1:0]]  = CMD_WDATA[0];
                    end
                end else if (CMD_ADDR < mcg_pkg::COIL_POLL_BASE) begin
                    off = CMD_ADDR - mcg_pkg::COIL_RST_BASE;
                    if (CMD_WDATA[0]) begin
                        s_d.rst_pend[off[2:0]] = 1'b1;
                    end
                end else if (CMD_ADDR < mcg_pkg::COIL_DELAY) begin
                    off = CMD_ADDR - mcg_pkg::COIL_POLL_BASE;
                    s_d.poll[off[IW-1:0]] = CMD_WDATA[0];
                    s_d.nv_save = 1'b1;
                end else if (CMD_ADDR == mcg_pkg::COIL_DELAY) begin
                    s_d.delay   = CMD_WDATA[0];
                    s_d.nv_save = 1'b1;
                end else if (CMD_ADDR <= mcg_pkg::COIL_LAST) begin
                    off = CMD_ADDR - mcg_pkg::COIL_TERM_BASE;
                    s_d.term[off[IW-1:0]] = CMD_WDATA[0];
                end else begin
                    s_d.rsp_err = 1'b1;
                end
            end else if (kind == mcg_pkg::MCG_VAL_RD && idx_ok) begin
                s_d.slot_busy  = 1'b1;
                s_d.slot_write = 1'b0;
                s_d.slot_idx   = CMD_ADDR[IW-1:0];
                s_d.slot_rsp   = !s_q.delay && !s_q.poll[CMD_ADDR[IW-1:0]];
                if (s_d.slot_rsp) begin
                    s_d.rsp_valid = 1'b0;
                end else begin
                    s_d.rsp_data = vs_rd_data;
                end
            end else if (kind == mcg_pkg::MCG_VAL_WR && idx_ok) begin
                s_d.slot_busy  = 1'b1;
                s_d.slot_write = 1'b1;
                s_d.slot_idx   = CMD_ADDR[IW-1:0];
                s_d.slot_data  = CMD_WDATA;
                s_d.slot_rsp   = !s_q.delay;
                if (!s_q.delay) begin
                    s_d.rsp_valid = 1'b0;
                end else begin
                    s_d.rsp_data = CMD_WDATA;
                end
            end else if (kind == mcg_pkg::MCG_REG_RD) begin
                if (CMD_ADDR == mcg_pkg::REG_TERM_LO) begin
                    s_d.rsp_data[15:0] = s_q.term[mcg_pkg::TERM_LO_BITS-1:0];
                end else if (CMD_ADDR == mcg_pkg::REG_TERM_HI) begin
                    s_d.rsp_data[2:0] = s_q.term[NV-1:mcg_pkg::TERM_LO_BITS];
                end else begin
                    s_d.rsp_err = 1'b1;
                end
            end else if (kind == mcg_pkg::MCG_REG_WR) begin
                if (CMD_ADDR == mcg_pkg::REG_TERM_LO) begin
                    s_d.term[mcg_pkg::TERM_LO_BITS-1:0] = CMD_WDATA[15:0];
                end else if (CMD_ADDR == mcg_pkg::REG_TERM_HI) begin
                    s_d.term[NV-1:mcg_pkg::TERM_LO_BITS] = CMD_WDATA[2:0];
                end else begin
                    s_d.rsp_err = 1'b1;
                end
            end else begin
                s_d.rsp_err = 1'b1;
            end
        end

        // Stored copy of the persistent coils for the storage writer
        s_d.nv_data = {s_d.delay, s_d.poll};
        // One master value transaction outstanding at a time
        s_d.cmd_ready = (s_d.st != MCG_ST_LOAD) && !s_d.slot_busy;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            s_q           <= '0;
            s_q.st        <= MCG_ST_LOAD;
            s_q.poll      <= mcg_pkg::POLL_RST;
            s_q.delay     <= mcg_pkg::DELAY_RST;
            s_q.term      <= mcg_pkg::TERM_RST;
            s_q.init_left <= '1;
            s_q.cur_src   <= mcg_pkg::MCG_SRC_POLL;
            s_q.mtr_op    <= mcg_pkg::MCG_MTR_READ;
            s_q.mtr_term  <= mcg_pkg::CHAR_NOSAVE;
            s_q.nv_data   <= {mcg_pkg::DELAY_RST, mcg_pkg::POLL_RST};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register

    assign CMD_READY    = s_q.cmd_ready;
    assign RSP_VALID    = s_q.rsp_valid;
    assign RSP_ERR      = s_q.rsp_err;
    assign RSP_DATA     = s_q.rsp_data;
    assign MTR_REQ      = s_q.mtr_req;
    assign MTR_OP       = s_q.mtr_op;
    assign MTR_SEL      = s_q.mtr_sel;
    assign MTR_WDATA    = s_q.mtr_wdata;
    assign MTR_TERM     = s_q.mtr_term;
    assign NV_SAVE      = s_q.nv_save;
    assign NV_SAVE_DATA = s_q.nv_data;

endmodule

`default_nettype wire

// File: mcg_gateway_properties.sv
// Purpose: Port assertions for the coil gateway
// Assumes: Meter link acks within a few tens of cycles
// Notes  : Poll and delay settings are read off NV_SAVE_DATA
`default_nettype none
module mcg_gateway_properties #(parameter int VAL_W = 32) (
    input wire logic             SYS_CLK,
    input wire logic             RST,
    input wire logic             CMD_VALID,
    input wire logic             CMD_READY,
    input wire logic [2:0]       CMD_KIND,
    input wire logic [15:0]      CMD_ADDR,
    input wire logic             RSP_VALID,
    input wire logic [VAL_W-1:0] RSP_DATA,
    input wire logic             MTR_REQ,
    input wire logic [1:0]       MTR_OP,
    input wire logic             MTR_ACK,
    input wire logic [19:0]      NV_SAVE_DATA
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    wire logic tk = CMD_VALID && CMD_READY;
    wire logic dly = NV_SAVE_DATA[19];
    ////////////////////////////////////////////////////////////////////////
    // First cycle skipped: it only shows the RSP_VALID that this take itself cleared
    sequence s_rd_slow;
        tk && CMD_KIND == 3'h2 && CMD_ADDR < 16'h13 && !dly
            && !NV_SAVE_DATA[CMD_ADDR[4:0]];
    endsequence
    sequence s_wr_slow; tk && CMD_KIND == 3'h3 && !dly; endsequence
    property p_hold; MTR_REQ && !MTR_ACK |=> MTR_REQ && $stable(MTR_OP);
    endproperty
    property p_gap; MTR_REQ && MTR_ACK |=> !MTR_REQ; endproperty
    property p_busy; tk && CMD_KIND inside {3'h2, 3'h3} && CMD_ADDR < 16'h13
        |=> !CMD_READY; endproperty
    property p_fast; tk && dly && CMD_KIND inside {3'h2, 3'h3} |=> RSP_VALID;
    endproperty
    property p_coil; tk && CMD_KIND inside {3'h0, 3'h1} |=> RSP_VALID;
    endproperty
    property p_slow_wr; s_wr_slow |=> ##1 !RSP_VALID [*3]; endproperty
    property p_slow_rd; s_rd_slow |=> ##1 !RSP_VALID ##[1:60] RSP_VALID;
    endproperty
    property p_rst0; tk && CMD_KIND == 3'h0 && CMD_ADDR inside {[16'h4:16'h9]}
        |=> RSP_DATA[0] == 1'b0; endproperty
    a_hold: assert property (p_hold)
        else $error("meter request moved");
    a_gap: assert property (p_gap)
        else $error("meter request held");
    a_busy: assert property (p_busy)
        else $error("ready while busy");
    a_fast: assert property (p_fast)
        else $error("answer late");
    a_coil: assert property (p_coil)
        else $error("coil answer late");
    a_slow_wr: assert property (p_slow_wr)
        else $error("write early");
    a_slow_rd: assert property (p_slow_rd)
        else $error("read timing");
    a_rst0: assert property (p_rst0)
        else $error("reset coil set");
endmodule
bind mcg_gateway mcg_gateway_properties #(.VAL_W(VAL_W)) chk_u (
    .SYS_CLK(SYS_CLK), .RST(RST), .CMD_VALID(CMD_VALID),
    .CMD_READY(CMD_READY), .CMD_KIND(CMD_KIND), .CMD_ADDR(CMD_ADDR),
    .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .MTR_REQ(MTR_REQ),
    .MTR_OP(MTR_OP), .MTR_ACK(MTR_ACK), .NV_SAVE_DATA(NV_SAVE_DATA));
`default_nettype wire

// File: mcg_gateway_test.sv
// Purpose: Self-checking bench for the coil gateway
// Assumes: Meter model holds value i as 0x1000 plus i
// Notes  : Answers are scored from a queue in command order
`default_nettype none
module mcg_gateway_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, cv = 1'b0, nvv = 1'b1;
    logic [2:0] ck = 3'h0;
    logic [15:0] ca = 16'h0;
    logic [31:0] cw = 32'h0, rd, mwd, mrd, w, sd = 32'h7251;
    logic [3:0] sp = 4'h0, man = 4'h0, lat = 4'h0;
    logic [19:0] nvd = 20'hfffdf, nvsd;
    logic [7:0] mterm;
    logic [4:0] msel;
    logic [1:0] mop;
    logic [33:0] e, exp_q[$];
    logic rdy, rv, rerr, mreq, mack, nvs;
    int n_fail = 0, num_checks = 0, cyc = 0;
    mcg_gateway dut_u (.SYS_CLK(clk), .RST(rst), .CMD_VALID(cv), .CMD_KIND(ck),
        .CMD_ADDR(ca), .CMD_WDATA(cw), .CMD_READY(rdy), .RSP_VALID(rv),
        .RSP_ERR(rerr), .RSP_DATA(rd), .SP_OUT_STATE(sp), .SP_MANUAL(man),
        .MTR_REQ(mreq), .MTR_OP(mop), .MTR_SEL(msel), .MTR_WDATA(mwd),
        .MTR_TERM(mterm), .MTR_ACK(mack), .MTR_RDATA(mrd), .NV_SAVE(nvs),
        .NV_LOAD_VALID(nvv), .NV_LOAD_DATA(nvd), .NV_SAVE_DATA(nvsd));
    mcg_meter_model mtr_u (.clk(clk), .req(mreq), .op(mop), .sel(msel),
        .wdata(mwd), .lat(lat), .ack(mack), .rdata(mrd));
    initial forever #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        sd = sd ^ (sd << 13);
        sd = sd ^ (sd >> 17);
        sd = sd ^ (sd << 5);
        return sd;
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(logic [32:0] seen, logic [32:0] ex, string what);
        num_checks++;
        if (seen !== ex) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, ex, seen);
        end
    endtask
    // Bit 33 of a note asks for the data, bit 32 is the error flag
    task automatic cmd(logic [2:0] k, logic [15:0] a, logic [31:0] d,
                       logic [33:0] x);
        @(posedge clk);
        #1 cv = 1'b1;
        ck = k;
        ca = a;
        cw = d;
        exp_q.push_back(x);
        while (rdy !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1 cv = 1'b0;
    endtask
    task automatic mwait(logic [1:0] op, logic [4:0] s, logic [7:0] t);
        while (!(mreq === 1'b1 && mop === op)) @(negedge clk);
        chk(33'({msel, op[0] ? (op[1] ? mwd[7:0] : mterm) : 8'h0}),
            33'({s, t}), "meter");
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        if (rv === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 34'h1ffffffff;
            chk({rerr, e[33] ? rd : 32'h0}, e[32:0],
                "answer");
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        repeat (3) @(negedge clk);
        chk(33'(nvsd), 33'h0fffdf, "nv load");
        repeat (200) @(posedge clk);
        #1 w = xs();
        sp = w[3:0];
        cmd(3'h2, 16'h5, 32'h0, {2'b10, 32'h1005});
        for (int a = 0; a < 10; a++) begin
            cmd(3'h0, 16'(a), 32'h0,
                {2'b10, 31'h0, a < 4 && sp[a]});
        end
        cmd(3'h4, 16'h9c6b, 32'h0, 34'h100000000);
        man = 4'h2;
        cmd(3'h1, 16'h1, 32'h1, 34'h0);
        mwait(2'h3, 5'h1, 8'h1);
        for (int k = 0; k < 6; k++) begin
            cmd(3'h1, 16'(4 + k), 32'h1, 34'h0);
            mwait(2'h2, 5'(k), 8'h0);
        end
        $display("test coils done");
        cmd(3'h5, 16'h9c69, w, 34'h0);
        cmd(3'h5, 16'h9c6a, 32'hfffffffd, 34'h0);
        cmd(3'h4, 16'h9c69, 32'h0, {18'h20000, w[15:0]});
        cmd(3'h4, 16'h9c6a, 32'h0, {2'b10, 32'h5});
        cmd(3'h3, 16'h11, w, {2'b10, w});
        mwait(2'h1, 5'h11, 8'h24);
        cmd(3'h3, 16'h12, w, {2'b10, w});
        mwait(2'h1, 5'h12, 8'h2a);
        $display("test terminators done");
        lat = 4'h6;
        cmd(3'h1, 16'h1d, 32'h0, 34'h0);
        chk(33'(nvs), 33'h1, "nv pulse");
        cmd(3'h2, 16'h5, 32'h0, {2'b10, 32'h1005});
        w = xs();
        cmd(3'h3, 16'h5, w, {2'b10, w});
        cmd(3'h1, 16'hf, 32'h1, 34'h0);
        cmd(3'h0, 16'hf, 32'h0, {2'b10, 32'h1});
        repeat (3) @(negedge clk);
        chk(33'(nvsd), 33'h07ffff, "nv save");
        repeat (60) @(negedge clk);
        chk(33'(exp_q.size()), 33'h0, "answers left");
        $display("test delay done");
        end_of_test();
    end
endmodule
`default_nettype wire

// File: mcg_meter_model.sv
// Purpose: Behavioural meter behind the command link
// Assumes: One command at a time, ack after lat extra cycles
// Notes  : Read data flips outside read acks so stale data never matches
`default_nettype none
module mcg_meter_model (
    input  wire logic        clk,
    input  wire logic        req,
    input  wire logic [1:0]  op,
    input  wire logic [4:0]  sel,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  lat,
    output var  logic        ack,
    output var  logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [0:18];
    logic [3:0]  cnt = 4'h0;
    initial for (int i = 0; i < 19; i++) mem[i] = 32'h1000 + i;
    initial ack = 1'b0;
    initial rdata = 32'h0;
    always @(posedge clk) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if (req && !ack) begin
            cnt <= cnt + 4'h1;
            if (cnt >= lat) begin
                cnt <= 4'h0;
                ack <= 1'b1;
                if (op == 2'h1) mem[sel] <= wdata;
                if (op == 2'h0) rdata <= mem[sel];
            end
        end
    end
endmodule
`default_nettype wire

// File: mcg_pkg.sv
// Purpose : Shared constants and types for the coil gateway
// Assumes : Coils are numbered from zero; coil n here is printed coil n+1
// Notes   : Polling and response-delay settings mirror nonvolatile storage
`default_nettype none

package mcg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes of the coil groups
    localparam int NUM_VAL = 19;
    localparam int NUM_OUT = 4;
    localparam int NUM_RST = 6;
    localparam int IDX_W   = 5;

    ////////////////////////////////////////////////////////////////////////
    // Coil addresses, zero based
    localparam logic [15:0] COIL_OUT_BASE  = 16'h0000;
    localparam logic [15:0] COIL_RST_BASE  = 16'h0004;
    localparam logic [15:0] COIL_POLL_BASE = 16'h000a;
    localparam logic [15:0] COIL_DELAY     = 16'h001d;
    localparam logic [15:0] COIL_TERM_BASE = 16'h001e;
    localparam logic [15:0] COIL_LAST      = 16'h0030;

    ////////////////////////////////////////////////////////////////////////
    // Holding registers for the terminating flags
    localparam logic [15:0] REG_TERM_LO  = 16'h9c69;
    localparam logic [15:0] REG_TERM_HI  = 16'h9c6a;
    localparam int          TERM_LO_BITS = 16;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset and terminating characters
    localparam logic [18:0] POLL_RST  = 19'h7ffff;
    localparam logic        DELAY_RST = 1'b1;
    localparam logic [18:0] TERM_RST  = 19'h00000;
    localparam logic [7:0]  CHAR_NOSAVE = 8'h24;
    localparam logic [7:0]  CHAR_SAVE   = 8'h2a;
    localparam int          NV_DELAY_BIT = 19;

    ////////////////////////////////////////////////////////////////////////
    // Commands from the protocol front end and to the meter
    typedef enum logic [2:0] {
        MCG_COIL_RD, MCG_COIL_WR, MCG_VAL_RD, MCG_VAL_WR,
        MCG_REG_RD, MCG_REG_WR
    } mcg_cmd_t;

    typedef enum logic [1:0] {
        MCG_MTR_READ, MCG_MTR_WRITE, MCG_MTR_RESET, MCG_MTR_OUTPUT
    } mcg_mop_t;

    typedef enum logic [2:0] {
        MCG_SRC_POLL, MCG_SRC_MREAD, MCG_SRC_MWRITE, MCG_SRC_RESET,
        MCG_SRC_OUT
    } mcg_src_t;

endpackage

`default_nettype wire

// File: mcg_poll_sel.sv
// Purpose : Picks the next value of the polling loop
// Assumes : Mask bit set means the value takes part in the loop
// Notes   : Round robin from the last polled index, purely combinational
`default_nettype none

module mcg_poll_sel (
    input  wire logic [mcg_pkg::NUM_VAL-1:0] mask,
    input  wire logic [mcg_pkg::IDX_W-1:0]   cur,
    output      logic [mcg_pkg::IDX_W-1:0]   nxt,
    output      logic                        any
);

    always_comb begin
        int j;
        j   = 0;
        nxt = cur;
        any = 1'b0;
        // Search backwards so the nearest successor is kept last
        for (int k = mcg_pkg::NUM_VAL; k >= 1; k--) begin
            j = (int'(cur) + k) % mcg_pkg::NUM_VAL;
            if (mask[j]) begin
                nxt = j[mcg_pkg::IDX_W-1:0];
                any = 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// File: mcg_value_store.sv
// Purpose : Internal copy of every polled meter value
// Assumes : One write port from the meter side, one combinational read
// Notes   : Flip-flop storage; cleared by reset until the first sweep
`default_nettype none

module mcg_value_store #(
    parameter int VAL_W = 32
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     wr_en,
    input  wire logic [mcg_pkg::IDX_W-1:0] wr_idx,
    input  wire logic [VAL_W-1:0]         wr_data,
    input  wire logic [mcg_pkg::IDX_W-1:0] rd_idx,
    output      logic [VAL_W-1:0]         rd_data
);

    typedef struct packed {
        logic [mcg_pkg::NUM_VAL-1:0][VAL_W-1:0] mem;
    } mcgv_state_t;

    mcgv_state_t s_q;
    mcgv_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (wr_en && (int'(wr_idx) < mcg_pkg::NUM_VAL)) begin
            s_d.mem[wr_idx] = wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Out of range index reads zero
    assign rd_data = (int'(rd_idx) < mcg_pkg::NUM_VAL) ? s_q.mem[rd_idx]
                                                       : '0;

endmodule

`default_nettype wire
